// File: rtl/rx_gain_ctrl.sv
// Receiver gain search, digital gain tracker and channel filter path
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Decimator and 16-tap FIR for one rail
// ---------------------------------------------------------------
module chan_rail
  import rx_gain_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       adc_bit,
  input  wire logic       adc_strobe,
  output logic            dec_valid,
  output logic [7:0]      fir_q
);
  logic [2:0] cnt_q;
  logic [3:0] ones_q;
  logic [3:0] dec_q;
  logic [3:0] tap_q [FIR_TAPS];
  logic [7:0] sum;

  // Count ones over a decimation block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      ones_q    <= '0;
      dec_q     <= '0;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      if (adc_strobe) begin
        cnt_q <= cnt_q + 3'd1;
        if (cnt_q == 3'(DEC_LEN - 1)) begin
          dec_q     <= ones_q + 4'(adc_bit);
          ones_q    <= '0;
          dec_valid <= 1'b1;
        end else begin
          ones_q <= ones_q + 4'(adc_bit);
        end
      end
    end
  end

  // Tap line of the channel filter
  genvar g;
  generate
    for (g = 0; g < FIR_TAPS; g++) begin : taps
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tap_q[g] <= '0;
        end else if (dec_valid) begin
          tap_q[g] <= (g == 0) ? dec_q : tap_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  always_comb begin
    sum = '0;
    for (int i = 0; i < FIR_TAPS; i++) begin
      sum = sum + 8'(tap_q[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fir_q <= '0;
    end else begin
      fir_q <= sum;
    end
  end
endmodule

// ---------------------------------------------------------------
// Top: bus slave, gain search, tracker
// ---------------------------------------------------------------
module rx_gain_ctrl
  import rx_gain_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  signal_strength_value,
  input  wire logic        strength_valid,
  input  wire logic        fifo_emptied,
  input  wire logic        bit_tick,
  input  wire logic        adc_i,
  input  wire logic        adc_q,
  input  wire logic        adc_strobe,
  output logic [2:0]       front_gain_in_use,
  output logic [14:0]      filter_divisor,
  output logic [7:0]       agc_reference,
  output logic [2:0]       digital_gain,
  output logic [10:0]      data_i,
  output logic [10:0]      data_q
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rs1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  rx_cfg_s    cfg_q;
  bw_s        bw_q;
  bw_s        afc_bw_q;
  logic [2:0] gain_choice_q;
  logic [7:0] wake_q;
  logic [7:0] digital_gain_tracker_setup_q;
  logic [7:0] lvl_q [5];
  logic [3:0] holdoff_q;
  logic       rearm_q;
  logic       wr_q;
  logic [7:0] wa_q;
  logic       take;
  rx_state_e  st_q;
  logic [2:0] gain_q;
  logic [31:0] rd_d;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && htrans[1] && hready;

  always_comb begin
    rd_d = '0;
    unique case (haddr[7:0])
      A_CTRL:  rd_d = {26'h0, cfg_q};
      A_AMP:   rd_d = {26'h0, front_gain_in_use, gain_choice_q};
      A_WAKE:  rd_d = {24'h0, wake_q};
      A_BW:    rd_d = {27'h0, bw_q};
      A_AFCBW: rd_d = {27'h0, afc_bw_q};
      A_DIGITAL_GAIN_TRACKER:  rd_d = {24'h0, digital_gain_tracker_setup_q};
      A_LVLA:  rd_d = {lvl_q[3], lvl_q[2], lvl_q[1], lvl_q[0]};
      A_LVLB:  rd_d = {20'h0, holdoff_q, lvl_q[4]};
      A_STAT:  rd_d = {13'h0, digital_gain, agc_reference, 5'h0, st_q};
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      wa_q   <= '0;
      hrdata <= '0;
    end else begin
      wr_q <= take && hwrite;
      if (take) begin
        wa_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q         <= '0;
      bw_q          <= BW_RST;
      afc_bw_q      <= BW_RST;
      gain_choice_q <= GAIN_AUTO;
      wake_q        <= WAKE_RST;
      digital_gain_tracker_setup_q  <= '0;
      holdoff_q     <= '0;
      rearm_q       <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        lvl_q[i] <= '0;
      end
    end else begin
      rearm_q <= 1'b0;
      if (wr_q) begin
        unique case (wa_q)
          A_CTRL: begin
            cfg_q   <= hwdata[5:0];
            rearm_q <= hwdata[6];
          end
          A_AMP:   gain_choice_q <= hwdata[2:0];
          A_WAKE:  wake_q <= hwdata[7:0];
          A_BW:    bw_q <= hwdata[4:0];
          A_AFCBW: afc_bw_q <= hwdata[4:0];
          A_DIGITAL_GAIN_TRACKER:  digital_gain_tracker_setup_q <= hwdata[7:0];
          A_LVLA: begin
            for (int i = 0; i < 4; i++) begin
              lvl_q[i] <= hwdata[8*i +: 8];
            end
          end
          A_LVLB: begin
            lvl_q[4]  <= hwdata[7:0];
            holdoff_q <= hwdata[11:8];
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Gain search state machine
  // ---------------------------------------------------------------
  logic       above;
  logic [7:0] pwr_q;
  logic       hit_q;
  logic [3:0] gap_q;
  logic [2:0] step;
  logic       fixed;

  assign above = signal_strength_value > wake_q;
  assign fixed = gain_choice_q != GAIN_AUTO && gain_choice_q != GAIN_RSVD;

  // Count levels passed: below level one gives max gain
  always_comb begin
    step = GAIN_MAX;
    for (int i = 0; i < 5; i++) begin
      if (pwr_q > lvl_q[i]) begin
        step = 3'(i + 2);
      end
    end
  end

  // Last strength sample seen while waiting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= '0;
    end else if (st_q == ST_WAIT && strength_valid) begin
      pwr_q <= signal_strength_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_OFF;
      hit_q <= 1'b0;
      gap_q <= '0;
    end else if (!cfg_q.rx_en) begin
      st_q  <= ST_OFF;
      hit_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_OFF: begin
          st_q  <= ST_WAIT;
          hit_q <= 1'b0;
        end
        ST_WAIT: begin
          if (strength_valid) begin
            hit_q <= above;
            if (above && hit_q) begin
              st_q <= ST_PICK;
            end
          end
        end
        ST_PICK: st_q <= ST_HOLD;
        ST_HOLD: begin
          hit_q <= 1'b0;
          if (rearm_q) begin
            st_q <= ST_WAIT;
          end else if (cfg_q.packet_mode && cfg_q.auto_rearm && fifo_emptied) begin
            st_q  <= ST_GAP;
            gap_q <= '0;
          end
        end
        ST_GAP: begin
          if (rearm_q) begin
            st_q <= ST_WAIT;
          end else if (gap_q >= holdoff_q) begin
            st_q <= ST_WAIT;
          end else if (bit_tick) begin
            gap_q <= gap_q + 4'd1;
          end
        end
        default: st_q <= ST_OFF;
      endcase
    end
  end

  // Chosen gain, held until a new search
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= GAIN_MAX;
    end else if (st_q == ST_PICK) begin
      gain_q <= step;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      front_gain_in_use <= GAIN_MAX;
    end else if (fixed) begin
      front_gain_in_use <= gain_choice_q;
    end else begin
      front_gain_in_use <= gain_q;
    end
  end

  // ---------------------------------------------------------------
  // Filter width and gain reference
  // ---------------------------------------------------------------
  bw_s        bw_use;
  logic [4:0] mant_v;
  logic [3:0] shift;
  logic [7:0] mant_db;
  logic [7:0] ref_d;

  // AFC width during startup search
  assign bw_use = (cfg_q.afc_en && st_q != ST_HOLD && st_q != ST_GAP) ? afc_bw_q : bw_q;
  assign shift  = 4'(bw_use.expo) + (cfg_q.ook ? 4'(SHIFT_OOK) : 4'(SHIFT_FSK));

  always_comb begin
    unique case (bw_use.mant)
      2'b00:   mant_v = 5'd16;
      2'b01:   mant_v = 5'd20;
      2'b10:   mant_v = 5'd24;
      default: mant_v = 5'd16;
    endcase
    unique case (bw_use.mant)
      2'b01:   mant_db = 8'(LOG_M20);
      2'b10:   mant_db = 8'(LOG_M24);
      default: mant_db = 8'(LOG_M16);
    endcase
    // Shift already counts the two from 2*width
    ref_d = 8'(NOISE_FLOOR + NF_DB + SNR_DB + FADE_DB + LOG_HALF_XO + LOG_OCT * SHIFT_FSK)
          - mant_db - 8'(LOG_OCT) * 8'(shift);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_divisor <= '0;
      agc_reference  <= '0;
    end else begin
      filter_divisor <= 15'(mant_v) << shift;
      agc_reference  <= ref_d;
    end
  end

  // ---------------------------------------------------------------
  // Channel rails and digital gain tracker
  // ---------------------------------------------------------------
  logic       dv_i;
  logic [7:0] fi;
  logic [7:0] fq;
  logic       bit2_q;
  logic       dstep;
  logic [14:0] wide_i;
  logic [14:0] wide_q;

  chan_rail u_rail_i (
    .clk        (clk),
    .rst_n      (rst_n),
    .adc_bit    (adc_i),
    .adc_strobe (adc_strobe),
    .dec_valid  (dv_i),
    .fir_q      (fi)
  );

  chan_rail u_rail_q (
    .clk        (clk),
    .rst_n      (rst_n),
    .adc_bit    (adc_q),
    .adc_strobe (adc_strobe),
    .dec_valid  (),
    .fir_q      (fq)
  );

  // Two bit periods per step, mode-independent
  assign dstep = bit_tick && bit2_q && digital_gain_tracker_setup_q != '0;
  // Unclipped scaled rails, so the tracker never sees a wrapped value
  assign wide_i = 15'(fi) << digital_gain;
  assign wide_q = 15'(fq) << digital_gain;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit2_q <= 1'b0;
    end else if (bit_tick) begin
      bit2_q <= !bit2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digital_gain <= '0;
    end else if (digital_gain_tracker_setup_q == '0) begin
      digital_gain <= '0;
    end else if (dstep) begin
      if (wide_i[14:10] != '0 || wide_q[14:10] != '0) begin
        if (digital_gain != '0) begin
          digital_gain <= digital_gain - 3'd1;
        end
      end else if (!wide_i[9] && !wide_q[9] && digital_gain != 3'h7) begin
        digital_gain <= digital_gain + 3'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_i <= '0;
      data_q <= '0;
    end else if (dv_i) begin
      data_i <= wide_i[10:0];
      data_q <= wide_q[10:0];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_wake_twice: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_WAIT && cfg_q.rx_en && strength_valid && above && hit_q |=> st_q == ST_PICK)
    else $error("wake after two samples missed");
  chk_wake_early: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_WAIT && !(strength_valid && above && hit_q) |=> st_q != ST_PICK)
    else $error("left wait too early");
  chk_pick_gain: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_PICK && cfg_q.rx_en |=> gain_q == $past(step) && st_q == ST_HOLD)
    else $error("gain pick wrong");
  chk_hold_gain: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_HOLD && $past(st_q) == ST_HOLD |-> $stable(gain_q))
    else $error("gain moved in hold");
  chk_no_rearm: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_HOLD && cfg_q.rx_en && cfg_q.packet_mode && !cfg_q.auto_rearm && !rearm_q
    |=> st_q == ST_HOLD)
    else $error("hold left without rearm");
  chk_auto_gap: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_HOLD && cfg_q.rx_en && cfg_q.packet_mode && cfg_q.auto_rearm
    && fifo_emptied && !rearm_q |=> st_q == ST_GAP)
    else $error("auto rearm missed");
  chk_rearm_req: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == ST_HOLD || st_q == ST_GAP) && rearm_q && cfg_q.rx_en |=> st_q == ST_WAIT)
    else $error("rearm request ignored");
  chk_rearm_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rearm_q && !wr_q |=> !rearm_q)
    else $error("rearm did not clear");
  chk_disable_off: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_q.rx_en |=> st_q == ST_OFF)
    else $error("disable kept search");
  chk_fixed_gain: assert property (@(posedge clk) disable iff (!rst_n)
    fixed |=> front_gain_in_use == $past(gain_choice_q))
    else $error("fixed gain not applied");
  chk_digital_gain_tracker_rate: assert property (@(posedge clk) disable iff (!rst_n)
    digital_gain != $past(digital_gain) && $past(digital_gain_tracker_setup_q) != '0
    |-> $past(bit_tick) && $past(bit2_q))
    else $error("tracker stepped off rate");
endmodule

// File: shared/rx_gain_pkg.sv
// Constants, layouts and types for the receiver gain controller
// ---------------------------------------------------------------
// Summary of operation
// - Front gain choice zero lets the automatic loop pick the gain
// - After enable, wait until strength beats wake level twice in a row
// - On wake, pick the best front gain step without host help
// - Hold the chosen gain for the packet; expose it as gain in use
// - Packet mode without auto rearm keeps the same gain next packet
// - Packet mode with auto rearm: after FIFO drain and holdoff, wait again
// - Listen rearm request in hold or holdoff sends the search back to waiting; in pick it is ignored
// - Continuous mode keeps gain until a listen rearm request
// - Five ascending step levels map input power onto six gain steps
// - AFC at startup uses AFC filter width during AFC and gain search
// - Gain reference is noise floor plus NF, SNR, bandwidth and fade terms
// - Digital gain tracker readjusts every two bit periods when enabled
// - Digital gain tracker behaves the same in every transfer mode
// - One-bit I and Q streams are decimated before later stages
// - Channel filtering uses a sixteen tap FIR
// - FSK width divisor is mantissa times two to exponent plus two
// - OOK width divisor is mantissa times two to exponent plus three
// - Mantissa codes zero, one, two select sixteen, twenty, twenty-four
// - Gain choice one to six forces fixed gain; code seven is reserved and acts like zero
// ---------------------------------------------------------------
package rx_gain_pkg;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_AMP   = 8'h04;
  localparam logic [7:0] A_WAKE  = 8'h08;
  localparam logic [7:0] A_BW    = 8'h0C;
  localparam logic [7:0] A_AFCBW = 8'h10;
  localparam logic [7:0] A_DIGITAL_GAIN_TRACKER  = 8'h14;
  localparam logic [7:0] A_LVLA  = 8'h18;
  localparam logic [7:0] A_LVLB  = 8'h1C;
  localparam logic [7:0] A_STAT  = 8'h20;
  localparam logic [2:0] GAIN_AUTO = 3'h0;
  localparam logic [2:0] GAIN_MAX  = 3'h1;
  localparam logic [2:0] GAIN_RSVD = 3'h7;
  localparam logic [7:0] WAKE_RST  = 8'hFF;
  localparam logic [4:0] BW_RST    = 5'h0A;
  localparam int DEC_LEN  = 8;
  localparam int FIR_TAPS = 16;
  localparam int SHIFT_FSK = 2;
  localparam int SHIFT_OOK = 3;
  // Reference terms in dB
  localparam int NOISE_FLOOR = -174;
  localparam int NF_DB       = 7;
  localparam int SNR_DB      = 8;
  localparam int FADE_DB     = 5;
  localparam int LOG_HALF_XO = 72;
  localparam int LOG_M16 = 12;
  localparam int LOG_M20 = 13;
  localparam int LOG_M24 = 14;
  localparam int LOG_OCT = 3;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_WAIT = 3'b001, ST_PICK = 3'b011,
    ST_HOLD = 3'b010, ST_GAP = 3'b110
  } rx_state_e;
  typedef struct packed {
    logic low_idx;
    logic ook;
    logic afc_en;
    logic auto_rearm;
    logic packet_mode;
    logic rx_en;
  } rx_cfg_s;
  typedef struct packed {
    logic [1:0] mant;
    logic [2:0] expo;
  } bw_s;
endpackage

// File: sim/test_rx_gain_ctrl.sv
// Self-checking bench for the receiver gain controller
`timescale 1ns/1ns
module test_rx_gain_ctrl
  import rx_gain_pkg::*;
;
  typedef struct packed {
    logic [4:0]  bw;
    logic        ook;
    logic [14:0] div;
    logic [7:0]  ref_db;
  } bw_row_s;

  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  level = 8'h10;
  logic [7:0]  signal_strength_value;
  logic        strength_valid;
  logic        fifo_emptied = 1'h0;
  logic        bit_tick;
  logic        adc_i;
  logic        adc_q;
  logic        adc_strobe;
  logic [2:0]  front_gain_in_use;
  logic [14:0] filter_divisor;
  logic [7:0]  agc_reference;
  logic [2:0]  digital_gain;
  logic [10:0] data_i;
  logic [10:0] data_q;
  int          err_count = 0;
  int          checks = 0;
  bw_row_s     rows [6] = '{
    '{5'h00, 1'h0, 15'h0040, 8'hA2}, '{5'h08, 1'h0, 15'h0050, 8'hA1},
    '{5'h10, 1'h0, 15'h0060, 8'hA0}, '{5'h07, 1'h0, 15'h2000, 8'h8D},
    '{5'h17, 1'h1, 15'h6000, 8'h88}, '{5'h0A, 1'h1, 15'h0280, 8'h98}};

  assign hready = hreadyout;
  always #25 clk = ~clk;

  rx_gain_ctrl dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .signal_strength_value(signal_strength_value), .strength_valid(strength_valid),
    .fifo_emptied(fifo_emptied), .bit_tick(bit_tick), .adc_i(adc_i), .adc_q(adc_q),
    .adc_strobe(adc_strobe), .front_gain_in_use(front_gain_in_use),
    .filter_divisor(filter_divisor), .agc_reference(agc_reference),
    .digital_gain(digital_gain), .data_i(data_i), .data_q(data_q));

  tx_model far_end (.clk(clk), .rst_n(reset_n), .level(level),
    .signal_strength_value(signal_strength_value), .strength_valid(strength_valid),
    .bit_tick(bit_tick), .adc_i(adc_i), .adc_q(adc_q), .adc_strobe(adc_strobe));

  // ---------------------------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'h1, d, x);
  endtask

  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_out(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string nm);
    logic [31:0] d;
    bus(a, 1'h0, 32'h0000_0000, d);
    cmp_reg(nm, e, d & m);
  endtask

  task automatic wait_state(input logic [2:0] e);
    logic [31:0] d;
    int          n;
    n = 0;
    bus(A_STAT, 1'h0, 32'h0000_0000, d);
    while (d[2:0] !== e && n < 60) begin
      bus(A_STAT, 1'h0, 32'h0000_0000, d);
      n++;
    end
    cmp_reg("state", {29'h0000_0000, e}, d & 32'h0000_0007);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_fifo();
    @(posedge clk);
    fifo_emptied <= 1'h1;
    @(posedge clk);
    fifo_emptied <= 1'h0;
  endtask

  task automatic gain_is(input logic [2:0] e);
    cycles(2);
    cmp_out("gain in use", {29'h0000_0000, e}, {29'h0000_0000, front_gain_in_use});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    cycles(6);
    gain_is(3'h1);
    cmp_out("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    cmp_out("hreadyout", 32'h0000_0001, {31'h0000_0000, hreadyout});
    chk_reg(A_WAKE, 32'hFFFF_FFFF, 32'h0000_00FF, "wake reset");
    chk_reg(A_BW, 32'hFFFF_FFFF, 32'h0000_000A, "width reset");
    wr(8'h40, 32'h0000_1234);
    chk_reg(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    wait_state(ST_OFF);
    $display("test reset finished");
    foreach (rows[i]) begin
      wr(A_BW, {27'h000_0000, rows[i].bw});
      wr(A_CTRL, {27'h000_0000, rows[i].ook, 4'h0});
      cycles(3);
      cmp_out("divisor", {17'h0_0000, rows[i].div}, {17'h0_0000, filter_divisor});
      cmp_out("reference", {24'h00_0000, rows[i].ref_db}, {24'h00_0000, agc_reference});
    end
    $display("test width table finished");
    wr(A_AFCBW, 32'h0000_0000);
    wr(A_BW, 32'h0000_000A);
    wr(A_CTRL, 32'h0000_0008);
    cycles(3);
    cmp_out("afc divisor", 32'h0000_0040, {17'h0_0000, filter_divisor});
    wr(A_WAKE, 32'h0000_0030);
    wr(A_CTRL, 32'h0000_0001);
    for (int c = 1; c < 7; c++) begin
      wr(A_AMP, 32'(c));
      gain_is(3'(c));
    end
    wr(A_AMP, 32'h0000_0000);
    wait_state(ST_WAIT);
    $display("test fixed gain finished");
    wr(A_LVLA, 32'hA080_6040);
    wr(A_LVLB, 32'h0000_03C0);
    wr(A_DIGITAL_GAIN_TRACKER, 32'h0000_0030);
    wr(A_CTRL, 32'h0000_000B);
    level <= 8'h90;
    wait_state(ST_HOLD);
    gain_is(3'h4);
    chk_reg(A_AMP, 32'h0000_0038, 32'h0000_0020, "gain readback");
    cmp_out("hold divisor", 32'h0000_0140, {17'h0_0000, filter_divisor});
    level <= 8'h10;
    pulse_fifo();
    cycles(20);
    chk_reg(A_STAT, 32'h0000_0007, 32'h0000_0002, "state kept");
    gain_is(3'h4);
    wr(A_CTRL, 32'h0000_004B);
    wait_state(ST_WAIT);
    chk_reg(A_CTRL, 32'h0000_00FF, 32'h0000_000B, "rearm readback");
    $display("test packet gain finished");
    wr(A_CTRL, 32'h0000_000F);
    level <= 8'hD0;
    wait_state(ST_HOLD);
    gain_is(3'h6);
    level <= 8'h10;
    pulse_fifo();
    chk_reg(A_STAT, 32'h0000_0007, 32'h0000_0006, "holdoff");
    wait_state(ST_WAIT);
    $display("test auto rearm finished");
    wr(A_CTRL, 32'h0000_0009);
    level <= 8'h50;
    wait_state(ST_HOLD);
    gain_is(3'h2);
    level <= 8'h10;
    pulse_fifo();
    cycles(20);
    chk_reg(A_STAT, 32'h0000_0007, 32'h0000_0002, "continuous kept");
    wr(A_CTRL, 32'h0000_0049);
    wait_state(ST_WAIT);
    $display("test continuous finished");
    cycles(400);
    cmp_out("digital gain", 32'h0000_0003, {29'h0000_0000, digital_gain});
    cmp_out("data i", 32'h0000_0200, {21'h00_0000, data_i});
    cmp_out("data q", 32'h0000_0200, {21'h00_0000, data_q});
    $display("test tracker finished");
    wr(A_CTRL, 32'h0000_0000);
    wait_state(ST_OFF);
    wr(A_CTRL, 32'h0000_0001);
    wait_state(ST_WAIT);
    level <= 8'h90;
    wait_state(ST_HOLD);
    @(posedge clk);
    reset_n <= 1'h0;
    cycles(2);
    gain_is(3'h1);
    cmp_out("hrdata in reset", 32'h0000_0000, hrdata);
    reset_n <= 1'h1;
    cycles(6);
    wait_state(ST_OFF);
    chk_reg(A_WAKE, 32'hFFFF_FFFF, 32'h0000_00FF, "wake after reset");
    $display("test second reset finished");
    wrap_up();
  end
endmodule

// File: sim/tx_model.sv
// Model of the distant transmitter and the front end that it feeds
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Strength samples, bit periods and one-bit converter streams
// ---------------------------------------------------------------
module tx_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] level,
  output logic [7:0]      signal_strength_value,
  output logic            strength_valid,
  output logic            bit_tick,
  output logic            adc_i,
  output logic            adc_q,
  output logic            adc_strobe
);
  logic [2:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q                 <= 3'h0;
      signal_strength_value <= 8'h00;
      strength_valid        <= 1'h0;
      bit_tick              <= 1'h0;
    end else begin
      cnt_q          <= cnt_q + 3'h1;
      strength_valid <= (cnt_q[1:0] == 2'h3);
      bit_tick       <= (cnt_q == 3'h7);
      // Value only meaningful with its strobe; toggles otherwise
      if (cnt_q[1:0] == 2'h3) begin
        signal_strength_value <= level;
      end else begin
        signal_strength_value <= ~signal_strength_value;
      end
    end
  end

  // Alternating preamble pattern on both rails
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_strobe <= 1'h0;
      adc_i      <= 1'h0;
      adc_q      <= 1'h1;
    end else begin
      adc_strobe <= cnt_q[0];
      adc_i      <= cnt_q[1];
      adc_q      <= ~cnt_q[1];
    end
  end
endmodule
